// ---- include/bsx_exec_regs.vh ----
// Constants for the branch, skip and shift execution block.
// Functional notes
// RULE_01: Register bit clear skip jumps PC by 2 or 3 when bit is zero.
// RULE_02: Register bit set skip jumps PC by 2 or 3 when bit is one.
// RULE_03: I/O bit clear skip adds 2 or 3 to PC on zero bit; flags kept.
// RULE_04: I/O bit set skip adds 2 or 3 to PC on one bit; flags kept.
// RULE_05: Generic flag-set branch goes to PC plus k plus 1 when flag s is one.
// RULE_06: Generic flag-clear branch goes to PC plus k plus 1 when flag s is zero.
// RULE_07: Equal branch needs zero flag one; not-equal needs it zero.
// RULE_08: Carry set and lower need carry one; carry clear and same-or-higher need zero.
// RULE_09: Minus branch needs negative one; plus branch needs negative zero.
// RULE_10: Signed ge needs N xor V zero; signed lt needs it one.
// RULE_11: Half-carry branches test the half-carry flag for one or zero.
// RULE_12: Transfer bit branches test the transfer flag for one or zero.
// RULE_13: Overflow branches test the overflow flag for one or zero.
// RULE_14: Interrupt branches test the global interrupt enable for one or zero.
// RULE_15: Left shift moves bits up, bit 0 zero, updates Z C N V H.
// RULE_16: Right shift moves bits down, bit 7 zero, updates Z C N V.
// RULE_17: Left rotate takes carry into bit 0, old bit 7 into carry.
// RULE_18: Right rotate takes carry into bit 7, old bit 0 into carry.
// RULE_19: Nibble swap exchanges register halves in one cycle, flags unchanged.
// RULE_20: Arithmetic right shift keeps bit 7, old bit 0 to carry.
// RULE_21: Branch takes 1 cycle untaken, 2 taken; skip adds 1 or 2.
`ifndef BSX_EXEC_REGS_VH
`define BSX_EXEC_REGS_VH

// ****************************************
// Operation codes
// ****************************************
`define BSX_OP_SKIP_REG_CLR  4'h0
`define BSX_OP_SKIP_REG_SET  4'h1
`define BSX_OP_SKIP_IO_CLR   4'h2
`define BSX_OP_SKIP_IO_SET   4'h3
`define BSX_OP_BR_FLAG_SET   4'h4
`define BSX_OP_BR_FLAG_CLR   4'h5
`define BSX_OP_SHL           4'h6
`define BSX_OP_SHR           4'h7
`define BSX_OP_ROTL          4'h8
`define BSX_OP_ROTR          4'h9
`define BSX_OP_SHR_ARITH     4'ha
`define BSX_OP_SWAP          4'hb
`define BSX_OP_BR_SIGNED_GE  4'hc
`define BSX_OP_BR_SIGNED_LT  4'hd

// ****************************************
// Status flag bit positions
// ****************************************
`define BSX_FLG_C 0
`define BSX_FLG_Z 1
`define BSX_FLG_N 2
`define BSX_FLG_V 3
`define BSX_FLG_S 4
`define BSX_FLG_H 5
`define BSX_FLG_T 6
`define BSX_FLG_I 7

// ****************************************
// Reset values and cycle counts
// ****************************************
`define BSX_FLAGS_RST     8'h00
`define BSX_PC_RST        16'h0000
`define BSX_CYC_BASE      2'h1
`define BSX_CYC_BR_TAKEN  2'h2
`define BSX_CYC_SKIP_ONE  2'h2
`define BSX_CYC_SKIP_TWO  2'h3

`endif

// ---- hw/bsx_exec.v ----
// Executes skip, conditional branch and single-register shift instructions.
`timescale 1ns/10ps
`default_nettype none
`include "bsx_exec_regs.vh"

module bsx_exec (
    input  wire        clock,
    input  wire        reset,
    input  wire        start,
    input  wire [3:0]  op,
    input  wire [15:0] pc_in,
    input  wire [7:0]  reg_value,
    input  wire [7:0]  io_value,
    input  wire [2:0]  bit_sel,
    input  wire [6:0]  offset_k,
    input  wire        next_two_word,
    input  wire [7:0]  flags_in,
    output wire        ready,
    output reg  [15:0] pc_q,
    output reg  [7:0]  result_q,
    output reg         result_we_q,
    output reg  [7:0]  flags_q,
    output reg         flags_we_q,
    output reg         done_q
);

// ****************************************
// State machine
// ****************************************
localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_WAIT = 2'b10;

reg [1:0] state_q;
reg [1:0] state_d;
reg [1:0] cnt_q;
reg [1:0] cnt_d;

// ****************************************
// Flag selection
// ****************************************
// One decoder serves both generic branches and the named flag aliases; the signed ge/lt branches use N xor V instead.
function flag_pick;
    input [7:0] f;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: begin
                flag_pick = f[`BSX_FLG_C]; // RULE_08
            end
            3'h1: begin
                flag_pick = f[`BSX_FLG_Z]; // RULE_07
            end
            3'h2: begin
                flag_pick = f[`BSX_FLG_N]; // RULE_09
            end
            3'h3: begin
                flag_pick = f[`BSX_FLG_V]; // RULE_13
            end
            3'h4: begin
                flag_pick = f[`BSX_FLG_S];
            end
            3'h5: begin
                flag_pick = f[`BSX_FLG_H]; // RULE_11
            end
            3'h6: begin
                flag_pick = f[`BSX_FLG_T]; // RULE_12
            end
            default: begin
                flag_pick = f[`BSX_FLG_I]; // RULE_14
            end
        endcase
    end
endfunction

// ****************************************
// Combinational execute
// ****************************************
wire [15:0] k_ext = {{9{offset_k[6]}}, offset_k};
wire [15:0] pc_seq = pc_in + 16'h0001;
wire [15:0] pc_br = pc_in + k_ext + 16'h0001;
wire [15:0] pc_skip = next_two_word ? (pc_in + 16'h0003) : (pc_in + 16'h0002);
wire [1:0]  cyc_skip = next_two_word ? `BSX_CYC_SKIP_TWO : `BSX_CYC_SKIP_ONE;
wire        sel_flag = flag_pick(flags_in, bit_sel);
wire        nxv = flags_in[`BSX_FLG_N] ^ flags_in[`BSX_FLG_V];

reg         skip;
reg         taken;
reg         shift_op;
reg         half_upd;
reg         carry_out;
reg  [7:0]  res;
reg  [7:0]  flg;
reg  [15:0] pc_d;
reg  [1:0]  cyc;

always @* begin
    skip      = 1'b0;
    taken     = 1'b0;
    shift_op  = 1'b0;
    half_upd  = 1'b0;
    carry_out = 1'b0;
    res       = reg_value;
    case (op)
        `BSX_OP_SKIP_REG_CLR: begin
            skip = ~reg_value[bit_sel]; // RULE_01
        end
        `BSX_OP_SKIP_REG_SET: begin
            skip = reg_value[bit_sel]; // RULE_02
        end
        `BSX_OP_SKIP_IO_CLR: begin
            skip = ~io_value[bit_sel]; // RULE_03
        end
        `BSX_OP_SKIP_IO_SET: begin
            skip = io_value[bit_sel]; // RULE_04
        end
        `BSX_OP_BR_FLAG_SET: begin
            taken = sel_flag; // RULE_05
        end
        `BSX_OP_BR_FLAG_CLR: begin
            taken = ~sel_flag; // RULE_06
        end
        `BSX_OP_BR_SIGNED_GE: begin
            taken = ~nxv; // RULE_10
        end
        `BSX_OP_BR_SIGNED_LT: begin
            taken = nxv; // RULE_10
        end
        `BSX_OP_SHL: begin
            shift_op  = 1'b1;
            half_upd  = 1'b1;
            res       = {reg_value[6:0], 1'b0}; // RULE_15
            carry_out = reg_value[7];
        end
        `BSX_OP_SHR: begin
            shift_op  = 1'b1;
            res       = {1'b0, reg_value[7:1]}; // RULE_16
            carry_out = reg_value[0];
        end
        `BSX_OP_ROTL: begin
            shift_op  = 1'b1;
            half_upd  = 1'b1;
            res       = {reg_value[6:0], flags_in[`BSX_FLG_C]}; // RULE_17
            carry_out = reg_value[7];
        end
        `BSX_OP_ROTR: begin
            shift_op  = 1'b1;
            res       = {flags_in[`BSX_FLG_C], reg_value[7:1]}; // RULE_18
            carry_out = reg_value[0];
        end
        `BSX_OP_SHR_ARITH: begin
            shift_op  = 1'b1;
            res       = {reg_value[7], reg_value[7:1]}; // RULE_20
            carry_out = reg_value[0];
        end
        `BSX_OP_SWAP: begin
            res = {reg_value[3:0], reg_value[7:4]}; // RULE_19
        end
        default: begin
            res = reg_value;
        end
    endcase
end

// Shift flags; the signed flag is left alone because these operations do not list it.
always @* begin
    flg = flags_in;
    if (shift_op) begin
        flg[`BSX_FLG_Z] = (res == 8'h00);
        flg[`BSX_FLG_C] = carry_out;
        flg[`BSX_FLG_N] = res[7];
        flg[`BSX_FLG_V] = res[7] ^ carry_out;
        if (half_upd) begin
            flg[`BSX_FLG_H] = reg_value[3]; // RULE_15
        end
    end
end

// Program counter and cycle cost.
always @* begin
    pc_d = pc_seq;
    cyc  = `BSX_CYC_BASE;
    if (skip) begin
        pc_d = pc_skip;
        cyc  = cyc_skip; // RULE_21
    end else if (taken) begin
        pc_d = pc_br; // RULE_05
        cyc  = `BSX_CYC_BR_TAKEN; // RULE_21
    end
end

// ****************************************
// Sequencing
// ****************************************
// A new instruction is refused while a multi-cycle one is still counting down.
assign ready = (state_q == ST_IDLE);

always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
        ST_IDLE: begin
            if (start && cyc != `BSX_CYC_BASE) begin
                state_d = ST_WAIT;
                cnt_d   = cyc - 2'h1;
            end
        end
        ST_WAIT: begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
            cnt_d   = 2'h0;
        end
    endcase
end

always @(posedge clock) begin
    if (reset) begin
        state_q     <= ST_IDLE;
        cnt_q       <= 2'h0;
        pc_q        <= `BSX_PC_RST;
        result_q    <= 8'h00;
        result_we_q <= 1'b0;
        flags_q     <= `BSX_FLAGS_RST;
        flags_we_q  <= 1'b0;
        done_q      <= 1'b0;
    end else begin
        state_q     <= state_d;
        cnt_q       <= cnt_d;
        result_we_q <= 1'b0;
        flags_we_q  <= 1'b0;
        done_q      <= 1'b0;
        if (state_q == ST_IDLE && start) begin
            pc_q     <= pc_d;
            result_q <= res;
            flags_q  <= flg;
            done_q   <= (cyc == `BSX_CYC_BASE);
            result_we_q <= shift_op || (op == `BSX_OP_SWAP);
            flags_we_q  <= shift_op;
        end else if (state_q == ST_WAIT && cnt_q == 2'h1) begin
            done_q <= 1'b1; // RULE_21
        end
    end
end

endmodule
`default_nettype wire

// ---- bench/bsx_exec_monitor.sv ----
// Assertion checker for the branch, skip and shift execution block.
`timescale 1ns/10ps
`default_nettype none
module bsx_exec_monitor (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        start,
    input wire logic [3:0]  op,
    input wire logic [15:0] pc_in,
    input wire logic [7:0]  reg_value,
    input wire logic [2:0]  bit_sel,
    input wire logic [6:0]  offset_k,
    input wire logic        next_two_word,
    input wire logic [7:0]  flags_in,
    input wire logic        ready,
    input wire logic [15:0] pc_q,
    input wire logic [7:0]  result_q,
    input wire logic [7:0]  flags_q,
    input wire logic        done_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire        acc = start & ready;
    wire [7:0]  rv  = reg_value;
    wire [15:0] tgt = pc_in + {{9{offset_k[6]}}, offset_k} + 16'h0001;
    sequence s_taken; !ready ##1 done_q; endsequence
    sequence s_skip2; !ready [*2] ##1 done_q; endsequence
    a_flag_set_br: assert property (acc && op == 4'h4 && flags_in[bit_sel] |=> pc_q == $past(tgt) ##0 s_taken)
        else $error("bad set branch");
    a_flag_clr_br: assert property (acc && op == 4'h5 && !flags_in[bit_sel] |=> pc_q == $past(tgt) ##0 s_taken)
        else $error("bad clear branch");
    a_signed_lt: assert property (acc && op == 4'hd && (flags_in[2] ^ flags_in[3]) |=> pc_q == $past(tgt))
        else $error("bad signed branch");
    a_skip_two: assert property (acc && op == 4'h0 && !rv[bit_sel] && next_two_word |=>
        pc_q == $past(pc_in) + 16'h0003 ##0 s_skip2)
        else $error("bad skip");
    a_shift_left: assert property (acc && op == 4'h6 |=> result_q == {$past(rv[6:0]), 1'b0} && flags_q[0] == $past(rv[7]))
        else $error("bad left shift");
    a_rotate_right: assert property (acc && op == 4'h9 |=> result_q == {$past(flags_in[0]), $past(rv[7:1])})
        else $error("bad right rotate");
    a_shift_arith: assert property (acc && op == 4'ha |=> result_q == {$past(rv[7]), $past(rv[7:1])})
        else $error("bad arith shift");
    a_swap_keep: assert property (acc && op == 4'hb |=> result_q == {$past(rv[3:0]), $past(rv[7:4])} && flags_q == $past(flags_in))
        else $error("bad swap");
endmodule
bind bsx_exec bsx_exec_monitor i_mon (.clock, .reset, .start, .op, .pc_in, .reg_value, .bit_sel, .offset_k,
    .next_two_word, .flags_in, .ready, .pc_q, .result_q, .flags_q, .done_q);
`default_nettype wire

// ---- bench/bsx_exec_test.sv ----
// Self-checking bench for the branch, skip and shift execution block.
`timescale 1ns/10ps
`default_nettype none
module bsx_exec_test;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        start = 1'b0;
    logic [3:0]  op = 4'h0;
    logic [7:0]  reg_value = 8'h00;
    logic [7:0]  io_value = 8'h00;
    logic [15:0] pc_in = 16'h0100;
    logic [2:0]  bit_sel = 3'h0;
    logic [6:0]  offset_k = 7'h00;
    logic        next_two_word = 1'b0;
    logic [7:0]  flags_in = 8'h00;
    wire         ready;
    wire  [15:0] pc_q;
    wire  [7:0]  result_q;
    wire         result_we_q;
    wire  [7:0]  flags_q;
    wire         flags_we_q;
    wire         done_q;
    int          fail_count = 0;
    int          checked = 0;
    int          cyc;
    always #20 clock = ~clock;
    bsx_exec i_bsx_exec (.clock, .reset, .start, .op, .pc_in, .reg_value, .io_value,
        .bit_sel, .offset_k, .next_two_word, .flags_in, .ready, .pc_q, .result_q, .result_we_q, .flags_q,
        .flags_we_q, .done_q);
    task automatic give_verdict;
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic exec(input logic [3:0] o, input logic [7:0] v, input logic [2:0] b, input logic [6:0] k,
                        input logic two, input logic [7:0] f);
        @(posedge clock);
        start <= 1'b1;
        op <= o;
        // I/O skips see the inverse on the working register, so reading the wrong operand shows up.
        reg_value <= (o[3:1] == 3'h1) ? ~v : v;
        io_value <= v;
        bit_sel <= b;
        offset_k <= k;
        next_two_word <= two;
        flags_in <= f;
        @(posedge clock);
        start <= 1'b0;
        cyc = 1;
        // Reading 1 ns after the edge lets that edge's own updates land before the result is read.
        #1;
        while (done_q !== 1'b1) begin
            if (cyc == 5) begin
                fail_count++;
                give_verdict();
            end
            @(posedge clock);
            #1;
            cyc++;
        end
    endtask
    task automatic t_skip;
        for (int i = 0; i < 16; i++) begin
            exec({2'b00, i[1:0]}, i[2] ? 8'h20 : 8'hdf, 3'h5, 7'h00, i[3], 8'h5a);
            check(pc_q, i[2] == i[0] ? (i[3] ? 16'h0103 : 16'h0102) : 16'h0101);
            check(cyc, i[2] == i[0] ? (i[3] ? 3 : 2) : 1);
            check(flags_q, 8'h5a);
        end
    endtask
    task automatic t_br;
        for (int i = 0; i < 32; i++) begin
            exec(i[4] ? 4'h5 : 4'h4, 8'h00, i[2:0], i[0] ? 7'h05 : 7'h7d, 1'b0,
                 i[3] ? 8'h01 << i[2:0] : ~(8'h01 << i[2:0]));
            check(pc_q, i[3] ^ i[4] ? (i[0] ? 16'h0106 : 16'h00fe) : 16'h0101);
            check(cyc, i[3] ^ i[4] ? 2 : 1);
        end
    endtask
    task automatic t_sgn;
        @(posedge clock);
        pc_in <= 16'hfffe;
        for (int i = 0; i < 8; i++) begin
            exec(i[2] ? 4'hd : 4'hc, 8'h00, 3'h0, 7'h05, 1'b0, {4'h0, i[1], i[0], 2'b00});
            check(pc_q, (i[0] ^ i[1]) == i[2] ? 16'h0004 : 16'hffff);
            check(cyc, (i[0] ^ i[1]) == i[2] ? 2 : 1);
        end
        exec(4'hf, 8'h81, 3'h0, 7'h05, 1'b0, 8'hff);
        check(pc_q, 16'hffff);
        check(cyc, 1);
    endtask
    task automatic t_sh;
        logic [7:0] r, f, v, e;
        logic [3:0] o;
        logic       c;
        for (int i = 0; i < 6; i++) begin
            o = 4'h6 + i[3:0];
            v = i[0] ? 8'h4c : 8'h81;
            f = i[0] ? 8'hd1 : 8'h20;
            c = f[0];
            case (o)
                4'h6: {c, r} = {v, 1'b0};
                4'h7: {r, c} = {1'b0, v};
                4'h8: {c, r} = {v, f[0]};
                4'h9: {r, c} = {f[0], v};
                4'ha: {r, c} = {v[7], v};
                default: r = {v[3:0], v[7:4]};
            endcase
            e = f;
            if (o != 4'hb) e[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
            if (o == 4'h6 || o == 4'h8) e[5] = v[3];
            exec(o, v, 3'h0, 7'h00, 1'b0, f);
            check(result_q, r);
            check(flags_q, e);
            check({cyc[1:0], result_we_q, flags_we_q}, {2'h1, 1'b1, o != 4'hb});
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_skip();
        t_br();
        t_sgn();
        t_sh();
        give_verdict();
    end
endmodule
`default_nettype wire
